// ---- core_model.sv ----
// stand-in core: takes interrupts, runs a short handler, returns
`timescale 1ns/1ps
module core_model
   import reset_irq_pkg::*;
(
   // clock and bench control
   input  wire logic          ref_clk,
   input  wire logic          gie_req,
   input  wire logic [3:0]    delay,
   // block side
   input  wire core_irq_out_t core_irq,
   output core_irq_ctl_t      core_ctl,
   output logic [3:0]         taken_vec
);
   initial begin
      core_ctl = '0;
      taken_vec = 4'h0;
      forever begin
         @(posedge ref_clk);
         core_ctl <= '{1'b0, 4'h0, 1'b0, gie_req, 1'b0};
         if (core_irq.req) begin
            // a large delay gives the slow answer
            repeat (delay + 1) @(posedge ref_clk);
            if (core_irq.req) taken_vec <= core_irq.vector;
            core_ctl <= '{core_irq.req, core_irq.vector, 1'b0, 1'b0, 1'b0};
            @(posedge ref_clk);
            core_ctl <= '0;
            // handler saves its own status copy, none by hardware
            repeat (2) @(posedge ref_clk);
            core_ctl <= '{1'b0, 4'h0, 1'b1, 1'b0, 1'b0};
         end
      end
   end
endmodule

// ---- reset_flags_and_ext_irq_ctrl.sv ----
// reset-cause flags, start-up delay and external interrupt control
`timescale 1ns/1ps
`include "reset_irq_defs.svh"

module reset_flags_and_ext_irq_ctrl
   import reset_irq_pkg::*;
#(
   parameter int unsigned STARTUP_LONG_CYC  = `STARTUP_LONG_CYC,
   parameter int unsigned STARTUP_SHORT_CYC = `STARTUP_SHORT_CYC
) (
   // clock and power-up reset
   input  wire logic          ref_clk,
   input  wire logic          rst,
   // pins
   input  wire logic          reset_pin_n,
   input  wire logic [1:0]    ext_irq_pin,
   // watchdog and start-up select
   input  wire logic          wdt_timeout,
   input  wire logic          fast_startup,
   // reset to the core
   output logic               core_reset,
   output logic               wdt_reset_pulse,
   // core interrupt handshake
   input  wire core_irq_ctl_t core_ctl,
   output core_irq_out_t      core_irq,
   // avalon-mm slave
   input  wire avmm_req_t     avs_req,
   output logic [31:0]        avs_readdata,
   output logic               avs_waitrequest
);

   localparam logic [2:0]  PIN_MIN_CYC = 3'(`PIN_RESET_MIN_CYC);
   localparam logic [20:0] LONG_CYC    = 21'(STARTUP_LONG_CYC);
   localparam logic [20:0] SHORT_CYC   = 21'(STARTUP_SHORT_CYC);

   // synchronisers
   logic [2:0]  rpin_sync_r;
   logic [1:0]  irq_s1_r;
   logic [1:0]  irq_s2_r;
   logic [1:0]  irq_prev_r;

   // reset sequencing
   logic [2:0]  pin_low_cnt_r;
   logic        pin_rst_active_r;
   logic        wdt_pulse_r;
   logic        wdt_pulse_d_r;
   logic        wdt_prev_r;
   logic [20:0] delay_cnt_r;
   logic        delay_busy_r;

   // registers
   logic        powerup_reset_seen_r;
   logic        pin_reset_seen_r;
   logic [1:0]  irq_pending_r;
   logic [1:0]  irq_enable_r;
   logic [3:0]  sense_r;
   logic        gie_r;

   // bus
   logic        resp_r;
   logic [31:0] rdata_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rpin_sync_r <= 3'h7;
         irq_s1_r    <= 2'h3;
         irq_s2_r    <= 2'h3;
         irq_prev_r  <= 2'h3;
      end else begin
         rpin_sync_r <= {rpin_sync_r[1:0], reset_pin_n};
         irq_s1_r    <= ext_irq_pin;
         irq_s2_r    <= irq_s1_r;
         irq_prev_r  <= irq_s2_r;
      end
   end

   wire rpin_high = rpin_sync_r[1];
   wire rpin_prev = rpin_sync_r[2];

   // pin reset recognised once low for the minimum time
   wire pin_low_long  = (pin_low_cnt_r == PIN_MIN_CYC);
   wire pin_rst_fire  = ~rpin_high & ~pin_rst_active_r & pin_low_long;
   wire pin_released  = pin_rst_active_r & rpin_high & ~rpin_prev;

   always_ff @(posedge ref_clk) begin
      if (rst | rpin_high) begin
         pin_low_cnt_r <= 3'h0;
      end else if (!pin_low_long) begin
         pin_low_cnt_r <= pin_low_cnt_r + 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pin_rst_active_r <= 1'b0;
      end else if (pin_rst_fire) begin
         pin_rst_active_r <= 1'b1;
      end else if (pin_released) begin
         pin_rst_active_r <= 1'b0;
      end
   end

   // one clock wide, whatever the width of the time-out input
   wire wdt_rise = wdt_timeout & ~wdt_prev_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         wdt_prev_r    <= 1'b0;
         wdt_pulse_r   <= 1'b0;
         wdt_pulse_d_r <= 1'b0;
      end else begin
         wdt_prev_r    <= wdt_timeout;
         wdt_pulse_r   <= wdt_rise & ~delay_busy_r;
         wdt_pulse_d_r <= wdt_pulse_r;
      end
   end

   wire wdt_pulse_fall = wdt_pulse_d_r & ~wdt_pulse_r;
   wire delay_start    = pin_released | wdt_pulse_fall;
   wire [20:0] delay_len = fast_startup ? SHORT_CYC : LONG_CYC;

   // power-up reset also runs the delay
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         delay_cnt_r  <= 21'h0;
         delay_busy_r <= 1'b1;
      end else if (pin_rst_active_r | ~rpin_high) begin
         delay_cnt_r  <= 21'h0;
         delay_busy_r <= 1'b1;
      end else if (delay_start) begin
         delay_cnt_r  <= 21'h0;
         delay_busy_r <= 1'b1;
      end else if (delay_busy_r) begin
         delay_cnt_r  <= delay_cnt_r + 21'h1;
         delay_busy_r <= (delay_cnt_r + 21'h1) < delay_len;
      end
   end

   // the raw pin keeps the core in reset with no clock running
   assign core_reset = ~reset_pin_n | delay_busy_r | wdt_pulse_r
                       | wdt_pulse_d_r | pin_rst_active_r;
   assign wdt_reset_pulse = wdt_pulse_r;

   // internal resets clear the i/o registers, not the cause flags
   wire io_reset = rst | pin_rst_active_r | wdt_pulse_r;

   // bus: one wait cycle, write and read data at the second edge
   wire        bus_req = avs_req.read | avs_req.write;
   wire [5:0]  bus_idx = avs_req.address[7:2];
   wire        lane0   = avs_req.byteenable[0];
   wire        wr_go   = avs_req.write & resp_r & lane0;
   wire [7:0]  wdata   = avs_req.writedata[7:0];
   wire        wr_cause = wr_go & (bus_idx == `IDX_RESET_CAUSE);
   wire        wr_ctrl  = wr_go & (bus_idx == `IDX_CORE_CTRL);
   wire        wr_flags = wr_go & (bus_idx == `IDX_EXT_IRQ_FLAGS);
   wire        wr_enab  = wr_go & (bus_idx == `IDX_EXT_IRQ_ENABLES);

   assign avs_waitrequest = bus_req & ~resp_r;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         resp_r <= 1'b0;
      end else begin
         resp_r <= bus_req & ~resp_r;
      end
   end

   // cause flags: set wins over a written zero
   wire pin_seen_clr = wr_cause & ~wdata[`BIT_PIN_RESET_SEEN];
   wire por_seen_clr = wr_cause & ~wdata[`BIT_POWERUP_SEEN];

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         powerup_reset_seen_r <= 1'b1;
         pin_reset_seen_r     <= 1'b0;
      end else begin
         if (pin_rst_fire) begin
            pin_reset_seen_r <= 1'b1;
         end else if (pin_seen_clr) begin
            pin_reset_seen_r <= 1'b0;
         end
         if (por_seen_clr) begin
            powerup_reset_seen_r <= 1'b0;
         end
      end
   end

   // enables and sense
   always_ff @(posedge ref_clk) begin
      if (io_reset) begin
         irq_enable_r <= 2'(`RST_EXT_IRQ_ENABLES >> `BIT_PIN0_IRQ);
         sense_r      <= 4'(`RST_CORE_CTRL);
      end else begin
         if (wr_enab) begin
            irq_enable_r <= wdata[`BIT_PIN1_IRQ:`BIT_PIN0_IRQ];
         end
         if (wr_ctrl) begin
            sense_r <= wdata[3:0];
         end
      end
   end

   // status is the core's own business, only the enable bit lives here
   always_ff @(posedge ref_clk) begin
      if (io_reset) begin
         gie_r <= 1'b0;
      end else if (core_ctl.ack) begin
         gie_r <= 1'b0;
      end else if (core_ctl.return_from_handler | core_ctl.gie_set) begin
         gie_r <= 1'b1;
      end else if (core_ctl.gie_clear) begin
         gie_r <= 1'b0;
      end
   end

   // per-pin sensing and flag
   wire [1:0] pin_active;
   wire [3:0] pin_vec [2];

   assign pin_vec[0] = `VEC_PIN0;
   assign pin_vec[1] = `VEC_PIN1;

   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : g_pin
         // the pin level is sensed whatever its direction
         wire         lvl  = irq_s2_r[g];
         wire         prev = irq_prev_r[g];
         sense_mode_t mode;
         wire         event_hit;
         wire         ack_me;
         wire         w1c;

         assign mode = sense_mode_t'(sense_r[2*g +: 2]);
         assign event_hit = (mode == SENSE_ANY_CHANGE) ? (lvl ^ prev)
                          : (mode == SENSE_FALLING) ? (prev & ~lvl)
                          : (mode == SENSE_RISING) ? (~prev & lvl)
                          : 1'b0;
         assign ack_me = core_ctl.ack & (core_ctl.ack_vector == pin_vec[g]);
         assign w1c    = wr_flags & wdata[`BIT_PIN0_IRQ + g];

         always_ff @(posedge ref_clk) begin
            if (io_reset) begin
               irq_pending_r[g] <=
                  1'(`RST_EXT_IRQ_FLAGS >> (`BIT_PIN0_IRQ + g));
            end else if (mode == SENSE_LOW_LEVEL) begin
               irq_pending_r[g] <= 1'b0;
            end else if (event_hit) begin
               irq_pending_r[g] <= 1'b1;
            end else if (ack_me | w1c) begin
               irq_pending_r[g] <= 1'b0;
            end
         end

         // level request lasts only while the pin is low
         assign pin_active[g] = irq_enable_r[g] &
            ((mode == SENSE_LOW_LEVEL) ? ~lvl : irq_pending_r[g]);
      end
   endgenerate

   // pin 0 has the lower vector and wins a tie
   wire       any_active = |pin_active;
   wire [3:0] win_vec    = pin_active[0] ? `VEC_PIN0 : `VEC_PIN1;

   assign core_irq.req    = gie_r & any_active & ~core_ctl.ack;
   assign core_irq.vector = win_vec;
   assign core_irq.gie    = gie_r;

   // read mux
   wire [7:0] rd_cause = {6'h00, pin_reset_seen_r, powerup_reset_seen_r};
   wire [7:0] rd_flags = {irq_pending_r[1], irq_pending_r[0], 6'h00};
   wire [7:0] rd_enab  = {irq_enable_r[1], irq_enable_r[0], 6'h00};
   wire [7:0] rd_ctrl  = {4'h0, sense_r};
   wire [7:0] rd_byte  = (bus_idx == `IDX_RESET_CAUSE)     ? rd_cause
                       : (bus_idx == `IDX_EXT_IRQ_FLAGS)   ? rd_flags
                       : (bus_idx == `IDX_EXT_IRQ_ENABLES) ? rd_enab
                       : (bus_idx == `IDX_CORE_CTRL)       ? rd_ctrl
                       : 8'h00;

   always_ff @(posedge ref_clk) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (avs_req.read & ~resp_r) begin
         rdata_r <= {24'h00_0000, rd_byte};
      end
   end

   assign avs_readdata = rdata_r;

endmodule

// ---- reset_flags_and_ext_irq_ctrl_assertions.sv ----
// assertion checker for the reset and external interrupt block
`timescale 1ns/1ps
module reset_flags_and_ext_irq_ctrl_assertions
   import reset_irq_pkg::*;
#(
   parameter int unsigned STARTUP_LONG_CYC  = 20,
   parameter int unsigned STARTUP_SHORT_CYC = 8
) (
   // clock and reset
   input wire logic          ref_clk,
   input wire logic          rst,
   // pins and watchdog
   input wire logic          reset_pin_n,
   input wire logic [1:0]    ext_irq_pin,
   input wire logic          wdt_timeout,
   input wire logic          fast_startup,
   // reset outputs
   input wire logic          core_reset,
   input wire logic          wdt_reset_pulse,
   // core and bus
   input wire core_irq_ctl_t core_ctl,
   input wire core_irq_out_t core_irq,
   input wire avmm_req_t     avs_req,
   input wire logic [31:0]   avs_readdata,
   input wire logic          avs_waitrequest
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   sequence bus_req_s;
      (avs_req.read || avs_req.write) && avs_waitrequest;
   endsequence
   sequence rd_done_s;
      avs_req.read && !avs_waitrequest;
   endsequence
   wdt_once_a: assert property (wdt_reset_pulse |=> !wdt_reset_pulse)
      else $error("watchdog pulse too long");
   // shortest start-up count is 8, so 8 cycles always hold
   wdt_hold_a: assert property (wdt_reset_pulse |-> core_reset [*8])
      else $error("core released too soon");
   pin_hold_a: assert property (!reset_pin_n |-> core_reset)
      else $error("core runs with pin low");
   ack_drop_a: assert property (core_ctl.ack |-> !core_irq.req)
      else $error("request during ack");
   ack_gie_a: assert property (core_ctl.ack |=> !core_irq.gie)
      else $error("global enable kept after ack");
   return_from_handler_gie_a: assert property (core_ctl.return_from_handler
      && !core_ctl.ack && !core_reset && !wdt_reset_pulse |=> core_irq.gie)
      else $error("return did not enable");
   req_gie_a: assert property (core_irq.req |-> core_irq.gie)
      else $error("request while disabled");
   bus_wait_a: assert property (bus_req_s |=> !avs_waitrequest)
      else $error("bus answer late");
   rsv_high_a: assert property (rd_done_s |-> avs_readdata[31:8] == 24'h0)
      else $error("upper read bits set");
   rsv_cause_a: assert property ((rd_done_s and
      avs_req.address == 8'hD0) |-> avs_readdata[7:2] == 6'h0)
      else $error("cause reserved bits set");
   rsv_irq_a: assert property ((rd_done_s and
      avs_req.address[7:3] == 5'h1D) |-> avs_readdata[5:0] == 6'h0)
      else $error("irq reserved bits set");
endmodule

bind reset_flags_and_ext_irq_ctrl reset_flags_and_ext_irq_ctrl_assertions #(
   .STARTUP_LONG_CYC  (STARTUP_LONG_CYC),
   .STARTUP_SHORT_CYC (STARTUP_SHORT_CYC)
) i_reset_flags_and_ext_irq_ctrl_assertions (
   .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
   .ext_irq_pin(ext_irq_pin), .wdt_timeout(wdt_timeout),
   .fast_startup(fast_startup), .core_reset(core_reset),
   .wdt_reset_pulse(wdt_reset_pulse), .core_ctl(core_ctl),
   .core_irq(core_irq), .avs_req(avs_req), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest)
);

// ---- reset_flags_and_ext_irq_ctrl_bench.sv ----
// self-checking bench for the reset and external interrupt block
`timescale 1ns/1ps
module reset_flags_and_ext_irq_ctrl_bench
   import reset_irq_pkg::*;
;
   logic          ref_clk = 1'b0;
   logic          rst = 1'b1;
   logic          reset_pin_n = 1'b1;
   logic [1:0]    ext_irq_pin = 2'h0;
   logic          wdt_timeout = 1'b0;
   logic          fast_startup = 1'b0;
   logic          core_reset;
   logic          wdt_reset_pulse;
   core_irq_ctl_t core_ctl;
   core_irq_out_t core_irq;
   avmm_req_t     avs_req = '0;
   logic [31:0]   avs_readdata;
   logic          avs_waitrequest;
   logic          gie_req = 1'b0;
   logic [3:0]    delay = 4'h0;
   logic [3:0]    taken_vec;
   logic [31:0]   rd;
   int            miscompares = 0;
   int            comparisons = 0;
   int            m, s;
   int            exp_vec[$];
   always #5 ref_clk = ~ref_clk;
   reset_flags_and_ext_irq_ctrl #(.STARTUP_LONG_CYC(20),
      .STARTUP_SHORT_CYC(8)) i_reset_flags_and_ext_irq_ctrl (
      .ref_clk(ref_clk), .rst(rst), .reset_pin_n(reset_pin_n),
      .ext_irq_pin(ext_irq_pin), .wdt_timeout(wdt_timeout),
      .fast_startup(fast_startup), .core_reset(core_reset),
      .wdt_reset_pulse(wdt_reset_pulse), .core_ctl(core_ctl),
      .core_irq(core_irq), .avs_req(avs_req),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
   core_model i_core_model (.ref_clk(ref_clk), .gie_req(gie_req),
      .delay(delay), .core_irq(core_irq), .core_ctl(core_ctl),
      .taken_vec(taken_vec));
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tmo();
      check(32'h0, 32'h1);
      summarize();
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      int k;
      @(posedge ref_clk);
      avs_req <= '{!wr, wr, a, {24'h0, d}, 4'hF};
      for (k = 0; k < 20; k++) begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
      end
      if (k == 20) tmo();
      rd = avs_readdata;
      avs_req <= '0;
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      check(rd, {24'h0, exp});
   endtask
   task automatic run_wait();
      int k;
      for (k = 0; k < 200; k++) begin
         @(posedge ref_clk);
         if (core_reset === 1'b0) break;
      end
      if (k == 200) tmo();
   endtask
   task automatic wdog();
      wdt_timeout <= 1'b1;
      @(posedge ref_clk);
      wdt_timeout <= 1'b0;
      run_wait();
   endtask
   task automatic take_chk();
      int k;
      logic [3:0] old;
      old = taken_vec;
      for (k = 0; k < 100; k++) begin
         @(posedge ref_clk);
         if (taken_vec !== old) break;
      end
      if (k == 100) tmo();
      check(taken_vec, exp_vec.pop_front());
   endtask
   initial begin
      s = $urandom(90);
      fast_startup <= 1'($urandom % 2);
      repeat (4) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (6) @(posedge ref_clk);
      check(core_reset, 1);
      run_wait();
      rdchk(8'hD0, 8'h01);
      bus(1'b1, 8'hD0, 8'hFE);
      rdchk(8'hD0, 8'h00);
      reset_pin_n <= 1'b0;
      repeat (12) @(posedge ref_clk);
      check(core_reset, 1);
      reset_pin_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check(core_reset, 1);
      run_wait();
      rdchk(8'hD0, 8'h02);
      wdog();
      rdchk(8'hD0, 8'h02);
      bus(1'b1, 8'hD0, 8'h00);
      wdog();
      rdchk(8'hD0, 8'h00);
      // enables stay off, so only an edge matching the sense mode must pend
      for (m = 0; m < 4; m++) begin
         s = $urandom % 2;
         ext_irq_pin <= {2{s[0]}};
         repeat (4) @(posedge ref_clk);
         bus(1'b1, 8'hD4, 8'(m * 5));
         bus(1'b1, 8'hE8, 8'hC0);
         ext_irq_pin <= ~{2{s[0]}};
         repeat (5) @(posedge ref_clk);
         rdchk(8'hE8, (m > 0 && (m == 1 || (m == 2) == s[0])) ? 8'hC0 : 8'h00);
         bus(1'b1, 8'hE8, 8'hC0);
         rdchk(8'hE8, 8'h00);
      end
      ext_irq_pin <= 2'h0;
      repeat (4) @(posedge ref_clk);
      bus(1'b1, 8'hE8, 8'hC0);
      ext_irq_pin <= 2'h3;
      bus(1'b1, 8'hEC, 8'hC0);
      repeat (5) @(posedge ref_clk);
      check(core_irq.req, 0);
      exp_vec = {1, 2};
      delay <= $urandom % 4;
      gie_req <= 1'b1;
      @(posedge ref_clk);
      gie_req <= 1'b0;
      take_chk();
      take_chk();
      repeat (10) @(posedge ref_clk);
      check(core_irq.gie, 1);
      rdchk(8'hE8, 8'h00);
      // level sense: request only while the pin is held low
      bus(1'b1, 8'hD4, 8'h00);
      exp_vec.push_back(1);
      ext_irq_pin <= 2'h2;
      take_chk();
      ext_irq_pin <= 2'h3;
      repeat (20) @(posedge ref_clk);
      check(core_irq.req, 0);
      rdchk(8'hE8, 8'h00);
      summarize();
   end
endmodule

// ---- reset_irq_defs.svh ----
// offsets, field positions, reset values and timing counts
`ifndef RESET_IRQ_DEFS_SVH
`define RESET_IRQ_DEFS_SVH

`define IDX_RESET_CAUSE      6'h34
`define IDX_CORE_CTRL        6'h35
`define IDX_EXT_IRQ_FLAGS    6'h3A
`define IDX_EXT_IRQ_ENABLES  6'h3B

`define BIT_POWERUP_SEEN     0
`define BIT_PIN_RESET_SEEN   1
`define BIT_PIN1_IRQ         7
`define BIT_PIN0_IRQ         6
`define POS_PIN0_SENSE       0
`define POS_PIN1_SENSE       2

`define RST_EXT_IRQ_FLAGS    8'h00
`define RST_EXT_IRQ_ENABLES  8'h00
`define RST_CORE_CTRL        8'h00

`define VEC_PIN0             4'h1
`define VEC_PIN1             4'h2

`define CLK_PERIOD_PS        10000
`define PIN_RESET_MIN_PS     50000
`define PIN_RESET_MIN_CYC    ((`PIN_RESET_MIN_PS + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define STARTUP_LONG_US      16000
`define STARTUP_SHORT_US     1100
// divide first: the product in ps would overflow 32 bits
`define STARTUP_LONG_CYC     (`STARTUP_LONG_US * (1000000 / `CLK_PERIOD_PS))
`define STARTUP_SHORT_CYC    (`STARTUP_SHORT_US * (1000000 / `CLK_PERIOD_PS))

`endif

// ---- reset_irq_pkg.sv ----
// types shared by the reset and external interrupt block
package reset_irq_pkg;

   typedef enum logic [1:0] {
      SENSE_LOW_LEVEL,
      SENSE_ANY_CHANGE,
      SENSE_FALLING,
      SENSE_RISING
   } sense_mode_t;

   typedef struct packed {
      logic        read;
      logic        write;
      logic [7:0]  address;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } avmm_req_t;

   typedef struct packed {
      logic       ack;
      logic [3:0] ack_vector;
      logic       return_from_handler;
      logic       gie_set;
      logic       gie_clear;
   } core_irq_ctl_t;

   typedef struct packed {
      logic       req;
      logic [3:0] vector;
      logic       gie;
   } core_irq_out_t;

endpackage
